// >>> src/usart_pkg.sv
// Package: register map, field positions, timing constants and types
package usart_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [9:0] MAIN_CTRL_INDEX = 10'h0ba;
  localparam logic [9:0] RX_STAT_INDEX = 10'h0bb;
  localparam logic [9:0] IRQ_CLK_INDEX = 10'h0bc;
  localparam logic [11:0] MAIN_CTRL_ADDR = {MAIN_CTRL_INDEX, 2'h0};
  localparam logic [11:0] RX_STAT_ADDR = {RX_STAT_INDEX, 2'h0};
  localparam logic [11:0] IRQ_CLK_ADDR = {IRQ_CLK_INDEX, 2'h0};
  localparam logic [11:0] TX_DATA_ADDR = 12'h0c0;
  localparam logic [11:0] RX_DATA_ADDR = 12'h0c4;
  localparam logic [11:0] BAUD_DIV_ADDR = 12'h0c8;
  localparam logic [7:0] MAIN_CTRL_RESET = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h000c;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] HALF_BIT = 4'h7;
  localparam logic [3:0] SHORT_STOP_LAST = 4'hd;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_SEVEN = 4'h7;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic parity_enable;
    logic parity_select_high;
    logic ninth_bit_or_parity_select_low;
    logic frame_length_high;
    logic frame_length_low;
  } main_cfg_type;

  typedef struct packed {
    logic two_stop_bits;
    logic short_last_stop;
    logic tx_pin_enable;
    logic sync_mode_select;
    logic rx_clock_source;
    logic tx_clock_source;
    logic rx_irq_enable;
    logic tx_irq_enable;
  } irq_clk_type;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b011,
    TX_PARITY = 3'b010,
    TX_STOP = 3'b110
  } tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b011,
    RX_PARITY = 3'b010,
    RX_STOP = 3'b110
  } rx_state_type;
endpackage

// >>> src/usart_control_status_regs.sv
// USART with its control and status registers behind an APB slave
module usart_control_status_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic serial_in_pin,
  input wire logic external_clock_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic clock_out_pin,
  // Interrupt requests
  output logic rx_irq,
  output logic tx_irq
);
  import usart_pkg::*;

  main_cfg_type main_r;
  irq_clk_type icfg_r;
  logic tx_buffer_empty_r, receive_buffer_full_r, err_r, ovr_r, fe_r, pe_r, spare_r, received_ninth_bit_r, attention_mode_r, transmitting_active_r, receive_line_fault_r;
  logic [7:0] tx_holding_buffer_r, rx_holding_buffer_r;
  logic [15:0] baud_div_r, baud_cnt_r;
  logic baud_tick_r, baud_clk_r, ck_prev_r, pready_r, pslverr_r, tx_par_r, tx_stop2_r, tx_out_r, rx_par_r;
  logic [1:0] rx_sync_r, ck_sync_r;
  logic [31:0] prdata_r;
  tx_state_type tx_state_r;
  rx_state_type rx_state_r;
  logic [3:0] tx_os_r, tx_bit_r, rx_os_r, rx_bit_r;
  logic [8:0] tx_shift_register_r, rx_shift_r;

  function automatic logic [3:0] frame_bits(input main_cfg_type c);
    if (c.frame_length_high) frame_bits = BITS_NINE;
    else if (c.frame_length_low) frame_bits = BITS_SEVEN;
    else frame_bits = BITS_EIGHT;
  endfunction

  // Access decode
  wire acc = psel && penable && !pready_r;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_main = paddr == MAIN_CTRL_ADDR;
  wire hit_stat = paddr == RX_STAT_ADDR;
  wire hit_icfg = paddr == IRQ_CLK_ADDR;
  wire hit_txd = paddr == TX_DATA_ADDR;
  wire hit_rxd = paddr == RX_DATA_ADDR;
  wire hit_baud = paddr == BAUD_DIV_ADDR;
  wire mapped = hit_main || hit_stat || hit_icfg || hit_txd || hit_rxd || hit_baud;
  wire tx_write = wr && hit_txd;
  wire rx_read = rd && hit_rxd;
  wire stat_read = rd && hit_stat;

  // Format decode
  wire nine_bit = main_r.frame_length_high;
  wire loopback = main_r.frame_length_high && main_r.frame_length_low;
  wire par_on = main_r.parity_enable && !nine_bit;
  wire [3:0] nbits = frame_bits(main_r);

  // Clock selection
  wire ck_in = ck_sync_r[1];
  wire ext_tick = ck_in && !ck_prev_r;
  wire tx_tick = icfg_r.tx_clock_source ? ext_tick : baud_tick_r;
  wire rx_tick = icfg_r.rx_clock_source ? ext_tick : baud_tick_r;
  wire os_last_tx = icfg_r.sync_mode_select ? 1'b1 : (tx_os_r == OVERSAMPLE_LAST);
  wire rx_line = loopback ? tx_out_r : rx_sync_r[1];
  wire rx_mid = icfg_r.sync_mode_select ? 1'b1 : (rx_os_r == OVERSAMPLE_LAST);

  // Parity of a data word under the current format
  function automatic logic par_bit(input logic [8:0] d, input main_cfg_type c);
    logic [8:0] m;
    m = c.frame_length_low ? {2'b00, d[6:0]} : {1'b0, d[7:0]};
    case ({c.parity_select_high, c.ninth_bit_or_parity_select_low})
      2'b10: par_bit = 1'b1;
      2'b11: par_bit = 1'b0;
      default: par_bit = ^m;
    endcase
  endfunction

  // Last stop bit length
  wire stop_last = tx_stop2_r ? 1'b0 : 1'b1;
  wire stop_end = icfg_r.sync_mode_select ? 1'b1 :
    ((stop_last && icfg_r.short_last_stop) ? (tx_os_r == SHORT_STOP_LAST) : (tx_os_r == OVERSAMPLE_LAST));

  // Received frame completion
  wire rx_done = rx_tick && rx_mid && rx_state_r == RX_STOP;
  wire rx_fe = rx_done && !rx_line;
  wire rx_ovr = rx_done && receive_buffer_full_r;
  wire [8:0] rx_word = main_r.frame_length_low && !nine_bit ? {2'b00, rx_shift_r[8:2]} :
    (nine_bit ? rx_shift_r : {1'b0, rx_shift_r[8:1]});
  wire rx_pe = rx_done && par_on && (rx_par_r != par_bit(rx_word, main_r));

  // APB answer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= WORD_ZERO;
    end else begin
      pready_r <= acc;
      pslverr_r <= acc && !mapped;
      if (rd) begin
        if (hit_main) prdata_r <= {24'h00_0000, main_r, err_r, receive_buffer_full_r, tx_buffer_empty_r};
        else if (hit_stat) prdata_r <= {24'h00_0000, ovr_r, fe_r, pe_r, spare_r, received_ninth_bit_r, attention_mode_r, transmitting_active_r, receive_line_fault_r};
        else if (hit_icfg) prdata_r <= {24'h00_0000, icfg_r};
        else if (hit_txd) prdata_r <= {24'h00_0000, tx_holding_buffer_r};
        else if (hit_rxd) prdata_r <= {24'h00_0000, rx_holding_buffer_r};
        else if (hit_baud) prdata_r <= {16'h0000, baud_div_r};
        else prdata_r <= WORD_ZERO;
      end
    end
  end

  // Control registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      main_r <= '0;
      icfg_r <= '0;
      spare_r <= 1'b0;
      baud_div_r <= BAUD_DIV_RESET;
    end else begin
      if (wr && hit_main) main_r <= pwdata[7:3];
      if (wr && hit_icfg) icfg_r <= pwdata[7:0];
      if (wr && hit_stat) spare_r <= pwdata[4];
      if (wr && hit_baud) baud_div_r <= pwdata[15:0];
    end
  end

  // Pin synchronisers and baud generator
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sync_r <= 2'b11;
      ck_sync_r <= 2'b00;
      ck_prev_r <= 1'b0;
      baud_cnt_r <= '0;
      baud_tick_r <= 1'b0;
      baud_clk_r <= 1'b0;
    end else begin
      rx_sync_r <= {rx_sync_r[0], serial_in_pin};
      ck_sync_r <= {ck_sync_r[0], external_clock_pin};
      ck_prev_r <= ck_sync_r[1];
      baud_tick_r <= baud_cnt_r == '0 && baud_div_r != '0;
      if (baud_cnt_r == '0) begin
        baud_cnt_r <= baud_div_r;
        if (baud_div_r != '0) baud_clk_r <= !baud_clk_r;
      end else begin
        baud_cnt_r <= baud_cnt_r - 16'h0001;
      end
    end
  end

  // Transmitter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_r <= TX_IDLE;
      tx_os_r <= '0;
      tx_bit_r <= '0;
      tx_shift_register_r <= '0;
      tx_holding_buffer_r <= ZERO_BYTE;
      tx_par_r <= 1'b0;
      tx_stop2_r <= 1'b0;
      tx_out_r <= 1'b1;
      tx_buffer_empty_r <= 1'b1;
      transmitting_active_r <= 1'b0;
    end else begin
      if (tx_write) begin
        tx_holding_buffer_r <= pwdata[7:0];
        tx_buffer_empty_r <= 1'b0;
      end
      case (tx_state_r)
        TX_IDLE: begin
          tx_out_r <= 1'b1;
          if (!tx_buffer_empty_r && !tx_write) begin
            tx_shift_register_r <= {main_r.ninth_bit_or_parity_select_low, tx_holding_buffer_r};
            tx_par_r <= par_bit({1'b0, tx_holding_buffer_r}, main_r);
            tx_buffer_empty_r <= 1'b1;
            transmitting_active_r <= 1'b1;
            tx_os_r <= '0;
            tx_state_r <= TX_START;
          end
        end
        TX_START: begin
          tx_out_r <= 1'b0;
          if (tx_tick) begin
            tx_os_r <= tx_os_r + 4'h1;
            if (os_last_tx) begin
              tx_os_r <= '0;
              tx_bit_r <= '0;
              tx_state_r <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          tx_out_r <= tx_shift_register_r[tx_bit_r];
          if (tx_tick) begin
            tx_os_r <= tx_os_r + 4'h1;
            if (os_last_tx) begin
              tx_os_r <= '0;
              tx_bit_r <= tx_bit_r + 4'h1;
              if (tx_bit_r == nbits - 4'h1) begin
                tx_stop2_r <= icfg_r.two_stop_bits;
                tx_state_r <= par_on ? TX_PARITY : TX_STOP;
              end
            end
          end
        end
        TX_PARITY: begin
          tx_out_r <= tx_par_r;
          if (tx_tick) begin
            tx_os_r <= tx_os_r + 4'h1;
            if (os_last_tx) begin
              tx_os_r <= '0;
              tx_state_r <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          tx_out_r <= 1'b1;
          if (tx_tick) begin
            tx_os_r <= tx_os_r + 4'h1;
            if (stop_end) begin
              tx_os_r <= '0;
              if (tx_stop2_r) tx_stop2_r <= 1'b0;
              else begin
                tx_state_r <= TX_IDLE;
                transmitting_active_r <= !tx_buffer_empty_r;
              end
            end
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // Receiver
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_r <= RX_IDLE;
      rx_os_r <= '0;
      rx_bit_r <= '0;
      rx_shift_r <= '0;
      rx_par_r <= 1'b0;
      rx_holding_buffer_r <= ZERO_BYTE;
      receive_buffer_full_r <= 1'b0;
      received_ninth_bit_r <= 1'b0;
    end else begin
      if (rx_read) receive_buffer_full_r <= 1'b0;
      case (rx_state_r)
        RX_IDLE: begin
          rx_os_r <= icfg_r.sync_mode_select ? OVERSAMPLE_LAST : HALF_BIT + 4'h1;
          if (!rx_line) rx_state_r <= RX_START;
        end
        RX_START: if (rx_tick) begin
          rx_os_r <= rx_os_r + 4'h1;
          if (rx_mid) begin
            rx_os_r <= '0;
            rx_bit_r <= '0;
            rx_state_r <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: if (rx_tick) begin
          rx_os_r <= rx_os_r + 4'h1;
          if (rx_mid) begin
            rx_os_r <= '0;
            rx_shift_r <= nine_bit ? {rx_line, rx_shift_r[8:1]} : {rx_line, rx_shift_r[8:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == nbits - 4'h1) rx_state_r <= par_on ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY: if (rx_tick) begin
          rx_os_r <= rx_os_r + 4'h1;
          if (rx_mid) begin
            rx_os_r <= '0;
            rx_par_r <= rx_line;
            rx_state_r <= RX_STOP;
          end
        end
        RX_STOP: if (rx_tick) begin
          rx_os_r <= rx_os_r + 4'h1;
          if (rx_mid) rx_state_r <= RX_IDLE;
        end
        default: rx_state_r <= RX_IDLE;
      endcase
      if (rx_done && !receive_buffer_full_r) begin
        rx_holding_buffer_r <= rx_word[7:0];
        receive_buffer_full_r <= 1'b1;
        if (nine_bit) received_ninth_bit_r <= rx_word[8];
      end
    end
  end

  // Error, attention and line fault flags
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovr_r <= 1'b0;
      fe_r <= 1'b0;
      pe_r <= 1'b0;
      err_r <= 1'b0;
      attention_mode_r <= 1'b0;
      receive_line_fault_r <= 1'b0;
    end else begin
      ovr_r <= rx_ovr || (ovr_r && !stat_read);
      fe_r <= rx_fe || (fe_r && !stat_read);
      pe_r <= rx_pe || (pe_r && !stat_read);
      err_r <= rx_ovr || rx_fe || rx_pe || (err_r && !stat_read);
      if (rx_done && nine_bit && rx_word[8]) attention_mode_r <= 1'b0;
      else if (wr && hit_stat) attention_mode_r <= pwdata[2];
      if (rx_fe) receive_line_fault_r <= 1'b1;
      else if (rx_line) receive_line_fault_r <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_out_pin <= 1'b1;
      serial_out_oe <= 1'b0;
      clock_out_pin <= 1'b0;
      rx_irq <= 1'b0;
      tx_irq <= 1'b0;
    end else begin
      serial_out_pin <= tx_out_r;
      serial_out_oe <= icfg_r.tx_pin_enable;
      clock_out_pin <= baud_clk_r;
      rx_irq <= receive_buffer_full_r && icfg_r.rx_irq_enable;
      tx_irq <= tx_buffer_empty_r && icfg_r.tx_irq_enable;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule // usart_control_status_regs

// >>> verification/usart_csr_checker.sv
// Checker for bus handshake and pin relations of the USART register block
module usart_csr_checker
  import usart_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and requests
  input wire logic serial_in_pin,
  input wire logic external_clock_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic clock_out_pin,
  input wire logic rx_irq,
  input wire logic tx_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire mapped = paddr inside {MAIN_CTRL_ADDR, RX_STAT_ADDR, IRQ_CLK_ADDR, TX_DATA_ADDR, RX_DATA_ADDR, BAUD_DIV_ADDR};
  wire in_access = psel && penable;
  wire cfg_wr = psel && pwrite && paddr == IRQ_CLK_ADDR;
  wire tx_hit = psel && pwrite && (paddr == TX_DATA_ADDR || paddr == IRQ_CLK_ADDR);
  wire rx_hit = psel && (paddr == RX_DATA_ADDR || paddr == IRQ_CLK_ADDR);
  logic [2:0] since_rx_r;
  // Cycles since the last access that may drop the receive request
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) since_rx_r <= 3'h7;
    else if (rx_hit) since_rx_r <= 3'h0;
    else if (since_rx_r != 3'h7) since_rx_r <= since_rx_r + 3'h1;
  end
  ready_after_access_a: assert property (in_access && !pready |=> pready)
    else $error("No pready after access phase");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(in_access))
    else $error("pready without access phase");
  err_decode_a: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  err_alone_a: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  unmapped_zero_a: assert property (pready && !pwrite && !mapped |-> prdata == WORD_ZERO)
    else $error("Unmapped read not zero");
  upper_zero_a: assert property (pready && !pwrite && paddr != BAUD_DIV_ADDR |-> prdata[31:8] == 24'h00_0000)
    else $error("Upper read bits not zero");
  oe_cause_a: assert property (!$stable(serial_out_oe) |-> $past(cfg_wr, 1) || $past(cfg_wr, 2) || $past(cfg_wr, 3))
    else $error("Pin enable changed without config write");
  tx_irq_drop_a: assert property ($fell(tx_irq) |-> $past(tx_hit, 1) || $past(tx_hit, 2) || $past(tx_hit, 3))
    else $error("Transmit request dropped without cause");
  rx_irq_drop_a: assert property ($fell(rx_irq) |-> since_rx_r < 3'h4)
    else $error("Receive request dropped without cause");
  low_width_a: assert property ($fell(serial_out_pin) |=> !serial_out_pin)
    else $error("Serial low pulse of one cycle");
endmodule // usart_csr_checker

bind usart_control_status_regs usart_csr_checker chk_i (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_in_pin(serial_in_pin), .external_clock_pin(external_clock_pin),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .clock_out_pin(clock_out_pin),
  .rx_irq(rx_irq), .tx_irq(tx_irq));

// >>> verification/remote_serial_peer.sv
// Remote serial transceiver model on the transmit and receive lines
module remote_serial_peer #(
  parameter int BIT_CYCLES = 32
) (
  // Clock
  input wire logic ref_clk,
  // Line from the block
  input wire logic serial_out_pin,
  // Line into the block
  output logic serial_in_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial serial_in_pin = 1'b1;
  // Frame bits LSB first; stays at the last bit level
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      serial_in_pin <= f[i];
      repeat (BIT_CYCLES) @(posedge ref_clk);
    end
  endtask
  // Mid-bit sampling from the first low level
  task automatic recv(output logic [11:0] f, input int n);
    int w;
    f = '0;
    w = 0;
    while (serial_out_pin !== 1'b0 && w < 400) begin
      w++;
      @(posedge ref_clk);
    end
    repeat (BIT_CYCLES / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      f[i] = serial_out_pin;
      repeat (BIT_CYCLES) @(posedge ref_clk);
    end
  endtask
endmodule // remote_serial_peer

// >>> verification/usart_control_status_regs_tb.sv
// Self-checking bench for the USART register block
module usart_control_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import usart_pkg::*;
  logic ref_clk, reset_n, psel, penable, pwrite, ext_clk, pready, pslverr, last_err;
  logic rx_pin, tx_pin, tx_oe, clk_out, rx_irq, tx_irq;
  logic [11:0] paddr, fr;
  logic [31:0] pwdata, prdata, rdata;
  int bad_count, comparisons;

  usart_control_status_regs dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(rx_pin), .external_clock_pin(ext_clk), .serial_out_pin(tx_pin), .serial_out_oe(tx_oe),
    .clock_out_pin(clk_out), .rx_irq(rx_irq), .tx_irq(tx_irq));
  remote_serial_peer peer (.ref_clk(ref_clk), .serial_out_pin(tx_pin), .serial_in_pin(rx_pin));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task report_and_stop;
    $display("Comparisons %0d, errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; waits for pready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        report_and_stop;
      end
      @(posedge ref_clk);
    end
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    report_and_stop;
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ext_clk = 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(MAIN_CTRL_ADDR, 32'hff, 32'h01);
    rd(RX_STAT_ADDR, 32'hff, 32'h00);
    rd(IRQ_CLK_ADDR, 32'hff, 32'h00);
    rd(12'h0fc, 32'hffff_ffff, 32'h00);
    chk(32'(last_err), 32'h1);
    wr(IRQ_CLK_ADDR, 32'hde);
    rd(IRQ_CLK_ADDR, 32'hff, 32'hde);
    chk(32'(tx_oe), 32'h0);
    wr(IRQ_CLK_ADDR, 32'h21);
    wr(BAUD_DIV_ADDR, 32'h1);
    chk(32'(tx_oe), 32'h1);
    chk(32'(tx_irq), 32'h1);
    // Baud clock output toggles every second cycle at divisor one
    repeat (16) @(posedge ref_clk);
    rdata = 32'(clk_out);
    repeat (2) @(posedge ref_clk);
    chk(32'(clk_out), rdata ^ 32'h1);
    // Even, mark and space parity on transmit
    for (int k = 0; k < 3; k++) begin
      wr(MAIN_CTRL_ADDR, 32'ha0 + 32'h20 * k);
      fork
        peer.recv(fr, 11);
        begin
          wr(TX_DATA_ADDR, 32'h57);
          rd(RX_STAT_ADDR, 32'h02, 32'h02);
        end
      join
      chk(32'(fr), 32'({2'b01, k < 2, 8'h57, 1'b0}));
      repeat (8) @(posedge ref_clk);
      rd(RX_STAT_ADDR, 32'h02, 32'h00);
    end
    // Receive, parity error, overrun, framing error
    wr(IRQ_CLK_ADDR, 32'h23);
    wr(MAIN_CTRL_ADDR, 32'ha0);
    peer.send({1'b1, 1'b0, 8'h3c, 1'b0}, 11);
    chk(32'(rx_irq), 32'h1);
    rd(MAIN_CTRL_ADDR, 32'hff, 32'ha3);
    rd(RX_DATA_ADDR, 32'hff, 32'h3c);
    rd(MAIN_CTRL_ADDR, 32'hff, 32'ha1);
    chk(32'(rx_irq), 32'h0);
    peer.send({1'b1, 1'b1, 8'h3c, 1'b0}, 11);
    rd(MAIN_CTRL_ADDR, 32'hff, 32'ha7);
    rd(RX_STAT_ADDR, 32'hff, 32'h20);
    rd(RX_STAT_ADDR, 32'hff, 32'h00);
    rd(RX_DATA_ADDR, 32'hff, 32'h3c);
    peer.send({1'b1, 1'b0, 8'h11, 1'b0}, 11);
    peer.send({1'b1, 1'b0, 8'h22, 1'b0}, 11);
    rd(RX_STAT_ADDR, 32'h80, 32'h80);
    rd(RX_DATA_ADDR, 32'hff, 32'h11);
    peer.send({1'b0, 1'b0, 8'h3c, 1'b0}, 11);
    rd(RX_STAT_ADDR, 32'h41, 32'h41);
    peer.send(12'hfff, 12);
    rd(RX_STAT_ADDR, 32'h01, 32'h00);
    rd(RX_DATA_ADDR, 32'hff, 32'h3c);
    // Nine-bit frame with attention mode
    wr(MAIN_CTRL_ADDR, 32'h10);
    wr(RX_STAT_ADDR, 32'h04);
    rd(RX_STAT_ADDR, 32'h1c, 32'h04);
    peer.send({1'b1, 9'h1a5, 1'b0}, 11);
    rd(RX_STAT_ADDR, 32'h0c, 32'h08);
    rd(RX_DATA_ADDR, 32'hff, 32'ha5);
    // Loopback
    wr(MAIN_CTRL_ADDR, 32'h18);
    wr(TX_DATA_ADDR, 32'h6b);
    rdata = '0;
    for (int i = 0; i < 200 && rdata[1] !== 1'b1; i++)
      apb(1'b0, MAIN_CTRL_ADDR, 32'h0);
    rd(RX_DATA_ADDR, 32'hff, 32'h6b);
    // Synchronous transmit on the external clock, two stop bits
    wr(MAIN_CTRL_ADDR, 32'h00);
    ext_clk <= 1'b1;
    repeat (40) @(posedge ref_clk);
    wr(IRQ_CLK_ADDR, 32'hb4);
    fork
      peer.recv(fr, 11);
      begin
        wr(TX_DATA_ADDR, 32'hc5);
        repeat (22) begin
          repeat (16) @(posedge ref_clk);
          ext_clk <= ~ext_clk;
        end
      end
    join
    chk(32'(fr), 32'({2'b11, 8'hc5, 1'b0}));
    rd(RX_STAT_ADDR, 32'h02, 32'h00);
    report_and_stop;
  end
endmodule // usart_control_status_regs_tb
